// file: dtp_defines.vh
`ifndef DTP_DEFINES_VH
`define DTP_DEFINES_VH
// tap state codes, 1149.1 walk
`define DTP_TS_RESET     4'h0
`define DTP_TS_IDLE      4'h1
`define DTP_TS_SEL_DR    4'h2
`define DTP_TS_CAP_DR    4'h3
`define DTP_TS_SHIFT_DR  4'h4
`define DTP_TS_EXIT1_DR  4'h5
`define DTP_TS_PAUSE_DR  4'h6
`define DTP_TS_EXIT2_DR  4'h7
`define DTP_TS_UPD_DR    4'h8
`define DTP_TS_SEL_IR    4'h9
`define DTP_TS_CAP_IR    4'hA
`define DTP_TS_SHIFT_IR  4'hB
`define DTP_TS_EXIT1_IR  4'hC
`define DTP_TS_PAUSE_IR  4'hD
`define DTP_TS_EXIT2_IR  4'hE
`define DTP_TS_UPD_IR    4'hF
// instructions
`define DTP_IR_SCAN_N    4'h2
`define DTP_IR_INTEST    4'hC
`define DTP_IR_IDENT     4'hE
`define DTP_IR_BYPASS    4'hF
`define DTP_IR_CAPTURE   4'h1
// coprocessor handshake encodings
`define DTP_HS_ABSENT    2'h2
`define DTP_HS_WAIT      2'h0
`define DTP_HS_GO        2'h1
`define DTP_HS_LAST      2'h3
// transfer size encodings
`define DTP_SZ_BYTE      2'h0
`define DTP_SZ_HALF      2'h1
`define DTP_SZ_WORD      2'h2
// debug control register bits
`define DTP_DCR_RQ_BIT   1
`define DTP_DCR_WIDTH    3
`define DTP_DCR_RESET    3'h0
// scan chain holding debug control
`define DTP_CHAIN_DCR    5'h02
`define DTP_CHAIN_RESET  5'h00
`endif

// file: dtp_debug_trace_port.v
`include "dtp_defines.vh"
module dtp_debug_trace_port #(
  parameter IR_W    = 4,
  parameter CHAIN_W = 5,
  parameter ID_W    = 32
) (
  // clock, reset, enable
  input  wire               sys_clk,
  input  wire               reset,
  input  wire               clkEnable,
  input  wire               debug_reset_n,
  // debug inputs
  input  wire               debug_feature_enable,
  input  wire               external_debug_request,
  input  wire               data_watchpoint_in,
  input  wire               instr_breakpoint_in,
  input  wire [1:0]         external_break_condition,
  // core status
  input  wire               coreRxFull,
  input  wire               coreTxEmpty,
  input  wire               coreDataReqEnd,
  input  wire               coreFetchEnd,
  input  wire               coreExecAdvance,
  input  wire               coreExecPassed,
  input  wire               coreDebugExit,
  input  wire [1:0]         coreWatchHit,
  // tap
  input  wire               test_clock_qualifier,
  input  wire               test_mode_select,
  input  wire               test_serial_in,
  input  wire               ext_chain_serial_in,
  input  wire [ID_W-1:0]    tap_ident_value,
  // core trace sources
  input  wire               trace_port_enable,
  input  wire [1:0]         coreHsDecode,
  input  wire [1:0]         coreHsExecute,
  input  wire [1:0]         coreDataSize,
  input  wire               coreMultiple,
  input  wire               coreDataReq,
  input  wire               coreWriteNext,
  input  wire               coreSeqNext,
  input  wire               coreCpFirstMem,
  input  wire               corePrevAbort,
  // debug outputs
  output reg                comms_rx_full,
  output reg                comms_tx_empty,
  output reg                debug_acknowledge,
  output reg                instr_executed,
  output reg  [1:0]         watch_match_out,
  output reg                internal_debug_request,
  output reg                debugHalt,
  // tap outputs
  output reg  [IR_W-1:0]    tap_instr_reg_out,
  output reg  [3:0]         tap_state_out,
  output reg  [CHAIN_W-1:0] selected_chain_id,
  output reg                test_serial_out,
  output reg                test_out_enable_n,
  output reg                ext_chain_serial_out,
  // trace outputs
  output reg  [1:0]         trace_cp_handshake_decode,
  output reg  [1:0]         trace_cp_handshake_execute,
  output reg  [1:0]         trace_data_size,
  output reg                trace_data_more,
  output reg                trace_data_request,
  output reg                trace_data_write_not_read,
  output reg                trace_data_sequential,
  output reg                trace_cp_late_cancel
);

  // a synchronised level moves only once stages two and three agree
  function settle;
    input [2:0] s;
    input       cur;
    begin
      settle = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // debug reset and pin inputs through three stages; change counts when 2 and 3 agree
  reg  [2:0] rstSync;
  reg        dbgRst;
  reg  [2:0] rqSync;
  reg        rqClean;
  reg  [2:0] enSync;
  reg        enClean;
  wire       dbgOn = enClean & ~dbgRst;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rstSync <= 3'h0;
      dbgRst  <= 1'b1;
      rqSync  <= 3'h0;
      rqClean <= 1'b0;
      enSync  <= 3'h0;
      enClean <= 1'b0;
    end else if (clkEnable) begin
      rstSync <= {rstSync[1:0], debug_reset_n};
      dbgRst  <= ~settle(rstSync, ~dbgRst);
      rqSync  <= {rqSync[1:0], external_debug_request};
      rqClean <= settle(rqSync, rqClean);
      enSync  <= {enSync[1:0], debug_feature_enable};
      enClean <= settle(enSync, enClean);
    end
  end

  // tap state machine
  reg [3:0]         tapState;
  reg [3:0]         next_tapState;
  reg [IR_W-1:0]    irShift;
  reg [ID_W-1:0]    drShift;
  reg [CHAIN_W-1:0] chainShift;
  // control bit one gates the external request into the core
  reg [`DTP_DCR_WIDTH-1:0] dbgCtrl;
  // qualifier only enables flops, the tap never runs on a clock of its own
  wire tck = test_clock_qualifier & dbgOn;

  // unknown codes fall back to test logic reset
  always @* begin
    next_tapState = tapState;
    case (tapState)
      `DTP_TS_RESET:    next_tapState = test_mode_select ? `DTP_TS_RESET : `DTP_TS_IDLE;
      `DTP_TS_IDLE:     next_tapState = test_mode_select ? `DTP_TS_SEL_DR : `DTP_TS_IDLE;
      `DTP_TS_SEL_DR:   next_tapState = test_mode_select ? `DTP_TS_SEL_IR : `DTP_TS_CAP_DR;
      `DTP_TS_CAP_DR:   next_tapState = test_mode_select ? `DTP_TS_EXIT1_DR : `DTP_TS_SHIFT_DR;
      `DTP_TS_SHIFT_DR: next_tapState = test_mode_select ? `DTP_TS_EXIT1_DR : `DTP_TS_SHIFT_DR;
      `DTP_TS_EXIT1_DR: next_tapState = test_mode_select ? `DTP_TS_UPD_DR : `DTP_TS_PAUSE_DR;
      `DTP_TS_PAUSE_DR: next_tapState = test_mode_select ? `DTP_TS_EXIT2_DR : `DTP_TS_PAUSE_DR;
      `DTP_TS_EXIT2_DR: next_tapState = test_mode_select ? `DTP_TS_UPD_DR : `DTP_TS_SHIFT_DR;
      `DTP_TS_UPD_DR:   next_tapState = test_mode_select ? `DTP_TS_SEL_DR : `DTP_TS_IDLE;
      `DTP_TS_SEL_IR:   next_tapState = test_mode_select ? `DTP_TS_RESET : `DTP_TS_CAP_IR;
      `DTP_TS_CAP_IR:   next_tapState = test_mode_select ? `DTP_TS_EXIT1_IR : `DTP_TS_SHIFT_IR;
      `DTP_TS_SHIFT_IR: next_tapState = test_mode_select ? `DTP_TS_EXIT1_IR : `DTP_TS_SHIFT_IR;
      `DTP_TS_EXIT1_IR: next_tapState = test_mode_select ? `DTP_TS_UPD_IR : `DTP_TS_PAUSE_IR;
      `DTP_TS_PAUSE_IR: next_tapState = test_mode_select ? `DTP_TS_EXIT2_IR : `DTP_TS_PAUSE_IR;
      `DTP_TS_EXIT2_IR: next_tapState = test_mode_select ? `DTP_TS_UPD_IR : `DTP_TS_SHIFT_IR;
      `DTP_TS_UPD_IR:   next_tapState = test_mode_select ? `DTP_TS_SEL_DR : `DTP_TS_IDLE;
      default:          next_tapState = `DTP_TS_RESET;
    endcase
  end

  wire irIdent = (tap_instr_reg_out == `DTP_IR_IDENT);
  wire irScanN = (tap_instr_reg_out == `DTP_IR_SCAN_N);
  wire irTest  = (tap_instr_reg_out == `DTP_IR_INTEST);
  // external chain reached when an intest selects a chain other than debug control
  wire useExt  = irTest & (selected_chain_id != `DTP_CHAIN_DCR);
  wire useDcr  = irTest & (selected_chain_id == `DTP_CHAIN_DCR);

  // shift states are the only ones presenting serial data
  function shiftState;
    input [3:0] s;
    begin
      shiftState = (s == `DTP_TS_SHIFT_DR) | (s == `DTP_TS_SHIFT_IR);
    end
  endfunction

  // chain return is tied low when absent, so the mux needs no guard
  reg next_serialOut;
  always @* begin
    next_serialOut = chainShift[0];
    if (tapState == `DTP_TS_SHIFT_IR)
      next_serialOut = irShift[0];
    else if (useExt)
      next_serialOut = ext_chain_serial_in;
    else if (irIdent | useDcr)
      next_serialOut = drShift[0];
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tapState          <= `DTP_TS_RESET;
      irShift           <= {IR_W{1'b0}};
      drShift           <= {ID_W{1'b0}};
      chainShift        <= {CHAIN_W{1'b0}};
      tap_instr_reg_out <= `DTP_IR_IDENT;
      selected_chain_id <= `DTP_CHAIN_RESET;
      dbgCtrl           <= `DTP_DCR_RESET;
    end else if (clkEnable) begin
      // debug reset puts tap, instruction and chain back to their reset values
      if (dbgRst) begin
        tapState          <= `DTP_TS_RESET;
        tap_instr_reg_out <= `DTP_IR_IDENT;
        selected_chain_id <= `DTP_CHAIN_RESET;
        dbgCtrl           <= `DTP_DCR_RESET;
      end else if (tck) begin
        tapState <= next_tapState;
        case (tapState)
          `DTP_TS_RESET: tap_instr_reg_out <= `DTP_IR_IDENT;
          `DTP_TS_CAP_IR: irShift <= `DTP_IR_CAPTURE;
          `DTP_TS_SHIFT_IR: irShift <= {test_serial_in, irShift[IR_W-1:1]};
          `DTP_TS_UPD_IR: tap_instr_reg_out <= irShift;
          // chains other than ident and debug control capture zeros
          `DTP_TS_CAP_DR: begin
            if (irIdent)
              drShift <= tap_ident_value;
            else if (useDcr)
              drShift <= {{(ID_W-`DTP_DCR_WIDTH){1'b0}}, dbgCtrl};
            else
              drShift <= {ID_W{1'b0}};
            chainShift <= selected_chain_id;
          end
          `DTP_TS_SHIFT_DR: begin
            drShift    <= {test_serial_in, drShift[ID_W-1:1]};
            chainShift <= {test_serial_in, chainShift[CHAIN_W-1:1]};
          end
          `DTP_TS_UPD_DR: begin
            if (irScanN)
              selected_chain_id <= chainShift;
            if (useDcr)
              dbgCtrl <= drShift[ID_W-1 -: `DTP_DCR_WIDTH];
          end
          default: ;
        endcase
      end
    end
  end

  // debug state
  reg inDebug;
  reg bkptPending;
  // watch and breakpoint inputs are same-clock, so they skip the synchroniser
  wire watchHit = dbgOn & data_watchpoint_in & coreDataReqEnd;
  wire bkptHit  = dbgOn & bkptPending & coreExecAdvance;
  wire rqHit    = dbgOn & rqClean & dbgCtrl[`DTP_DCR_RQ_BIT];
  wire debugEntry = watchHit | bkptHit | rqHit;
  // external break condition is accepted but no comparator here reads it

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inDebug     <= 1'b0;
      bkptPending <= 1'b0;
    end else if (clkEnable) begin
      // debug enable low leaves debug at once instead of waiting for an exit
      if (dbgRst | ~enClean) begin
        inDebug     <= 1'b0;
        bkptPending <= 1'b0;
      end else begin
        // a newer fetch replaces the flag, so only the instruction reaching execute counts
        if (coreFetchEnd)
          bkptPending <= instr_breakpoint_in;
        else if (coreExecAdvance)
          bkptPending <= 1'b0;
        // entry wins over a simultaneous exit
        if (debugEntry)
          inDebug <= 1'b1;
        else if (coreDebugExit)
          inDebug <= 1'b0;
      end
    end
  end

  // debug outputs, quiet during debug reset
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      comms_rx_full          <= 1'b0;
      comms_tx_empty         <= 1'b0;
      debug_acknowledge      <= 1'b0;
      instr_executed         <= 1'b0;
      watch_match_out        <= 2'h0;
      internal_debug_request <= 1'b0;
      debugHalt              <= 1'b0;
      tap_state_out          <= `DTP_TS_RESET;
      test_serial_out        <= 1'b0;
      test_out_enable_n      <= 1'b1;
      ext_chain_serial_out   <= 1'b0;
    end else if (clkEnable) begin
      if (dbgRst) begin
        comms_rx_full          <= 1'b0;
        comms_tx_empty         <= 1'b0;
        debug_acknowledge      <= 1'b0;
        instr_executed         <= 1'b0;
        watch_match_out        <= 2'h0;
        internal_debug_request <= 1'b0;
        debugHalt              <= 1'b0;
        tap_state_out          <= `DTP_TS_RESET;
        test_serial_out        <= 1'b0;
        test_out_enable_n      <= 1'b1;
        ext_chain_serial_out   <= 1'b0;
      end else begin
        comms_rx_full          <= dbgOn & coreRxFull;
        comms_tx_empty         <= dbgOn & coreTxEmpty;
        debug_acknowledge      <= inDebug;
        instr_executed         <= coreExecPassed;
        watch_match_out        <= dbgOn ? coreWatchHit : 2'h0;
        internal_debug_request <= rqHit;
        debugHalt              <= debugEntry | inDebug;
        // state is reported one cycle late, aligned with the serial output
        tap_state_out          <= tapState;
        test_serial_out        <= next_serialOut;
        test_out_enable_n      <= ~shiftState(tapState);
        ext_chain_serial_out   <= test_serial_in;
      end
    end
  end

  // trace stage: inputs already carry the handshake and size encodings
  // outputs hold while trace is disabled, keeping the last sample
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trace_cp_handshake_decode  <= `DTP_HS_ABSENT;
      trace_cp_handshake_execute <= `DTP_HS_ABSENT;
      trace_data_size            <= `DTP_SZ_BYTE;
      trace_data_more            <= 1'b0;
      trace_data_request         <= 1'b0;
      trace_data_write_not_read  <= 1'b0;
      trace_data_sequential      <= 1'b0;
      trace_cp_late_cancel       <= 1'b0;
    end else if (clkEnable & trace_port_enable) begin
      trace_cp_handshake_decode  <= coreHsDecode;
      trace_cp_handshake_execute <= coreHsExecute;
      trace_data_size            <= coreDataSize;
      trace_data_more            <= coreMultiple & coreDataReq;
      trace_data_request         <= coreDataReq;
      trace_data_write_not_read  <= coreWriteNext;
      trace_data_sequential      <= coreSeqNext;
      trace_cp_late_cancel       <= coreCpFirstMem & corePrevAbort;
    end
  end

endmodule // dtp_debug_trace_port

// file: dtp_ext_chain.sv
// stand-in external scan chain: one flop between serial out and return
module dtp_ext_chain (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic serialToChain,
  output logic      serialFromChain
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) serialFromChain <= 1'b0;
    else serialFromChain <= serialToChain;
  end
endmodule // dtp_ext_chain

// file: dtp_debug_trace_port_assertions.sv
`include "dtp_defines.vh"
module dtp_debug_trace_port_assertions (
  input wire logic       sys_clk, reset, clkEnable, trace_port_enable, test_clock_qualifier, debug_feature_enable,
  input wire logic [1:0] coreHsDecode, coreDataSize, trace_cp_handshake_decode, trace_data_size,
  input wire logic       coreMultiple, coreDataReq, coreCpFirstMem, corePrevAbort, trace_data_more,
  input wire logic       trace_cp_late_cancel, test_out_enable_n, debug_acknowledge, internal_debug_request,
  input wire logic [3:0] tap_instr_reg_out, tap_state_out,
  input wire logic [4:0] selected_chain_id
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire trOn = trace_port_enable && clkEnable;
  function automatic logic inShift(input logic [3:0] s);
    return s == `DTP_TS_SHIFT_DR || s == `DTP_TS_SHIFT_IR;
  endfunction
  a_trace_size: assert property (trOn |=> trace_data_size == $past(coreDataSize))
    else $error("trace size not one stage late");
  a_trace_hold: assert property (!trOn |=> $stable(trace_data_size) && $stable(trace_data_more))
    else $error("trace outputs moved while disabled");
  a_more_gate: assert property (trOn |=> trace_data_more == $past(coreMultiple && coreDataReq))
    else $error("data more wrong");
  a_late_cancel: assert property (trOn |=> trace_cp_late_cancel == $past(coreCpFirstMem && corePrevAbort))
    else $error("late cancel wrong");
  a_hs_decode: assert property (trOn |=> trace_cp_handshake_decode == $past(coreHsDecode))
    else $error("decode handshake wrong");
  a_oen_shift: assert property (!test_out_enable_n |-> inShift(tap_state_out) || inShift($past(tap_state_out)))
    else $error("serial out enabled outside shift");
  a_ir_update: assert property ($changed(tap_instr_reg_out) |-> tap_state_out == `DTP_TS_UPD_IR
    || $past(tap_state_out) == `DTP_TS_UPD_IR || tap_instr_reg_out == `DTP_IR_IDENT) else $error("ir moved off update");
  a_chain_update: assert property ($changed(selected_chain_id) |-> tap_state_out == `DTP_TS_UPD_DR
    || $past(tap_state_out) == `DTP_TS_UPD_DR || selected_chain_id == `DTP_CHAIN_RESET) else $error("chain moved");
  a_tap_qual: assert property ($changed(tap_state_out) |-> $past(test_clock_qualifier && clkEnable)
    || $past(test_clock_qualifier && clkEnable, 2) || tap_state_out == `DTP_TS_RESET) else $error("tap moved unqualified");
  a_debug_off: assert property ((!debug_feature_enable && clkEnable)[*8] |=> !debug_acknowledge
    && !internal_debug_request) else $error("debug active while disabled");
  c_more: cover property (trOn ##1 trace_data_more);
  c_shift: cover property (!test_out_enable_n);
  c_debug: cover property ($rose(debug_acknowledge));
endmodule // dtp_debug_trace_port_assertions

// file: tb_debug_trace_signal_port.sv
`include "dtp_defines.vh"
module tb_debug_trace_signal_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, clkEnable, debug_reset_n, debug_feature_enable, external_debug_request, data_watchpoint_in,
    instr_breakpoint_in, coreRxFull, coreTxEmpty, coreDataReqEnd, coreFetchEnd, coreExecAdvance, coreExecPassed,
    coreDebugExit, test_clock_qualifier, test_mode_select, test_serial_in, ext_chain_serial_in, trace_port_enable,
    coreMultiple, coreDataReq, coreWriteNext, coreSeqNext, coreCpFirstMem, corePrevAbort;
  logic [1:0] external_break_condition, coreWatchHit, coreHsDecode, coreHsExecute, coreDataSize;
  logic [31:0] tap_ident_value, r, got;
  logic comms_rx_full, comms_tx_empty, debug_acknowledge, instr_executed, internal_debug_request, debugHalt,
    test_serial_out, test_out_enable_n, ext_chain_serial_out, trace_data_more, trace_data_request,
    trace_data_write_not_read, trace_data_sequential, trace_cp_late_cancel;
  logic [1:0] watch_match_out, trace_cp_handshake_decode, trace_cp_handshake_execute, trace_data_size;
  logic [3:0] tap_instr_reg_out, tap_state_out;
  logic [4:0] selected_chain_id;
  logic [10:0] expTr;
  logic q[$];
  int errors, samples_checked;
  wire [10:0] trOut = {trace_cp_handshake_decode, trace_cp_handshake_execute, trace_data_size, trace_data_more,
    trace_data_request, trace_data_write_not_read, trace_data_sequential, trace_cp_late_cancel};
  dtp_debug_trace_port u_dut (.*);
  dtp_ext_chain u_chain (.sys_clk(sys_clk), .reset(reset), .serialToChain(ext_chain_serial_out),
    .serialFromChain(ext_chain_serial_in));
  always #25 sys_clk = ~sys_clk;
  task end_sim;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task tms(input logic m, d);
    test_mode_select = m;
    test_serial_in = d;
    @(negedge sys_clk);
    if (test_out_enable_n === 1'b0) q.push_back(test_serial_out);
  endtask
  // both scans leave the tap in idle with one settling cycle for the lagged outputs
  task ir(input logic [3:0] v);
    tms(1, 0); tms(1, 0); tms(0, 0); tms(0, 0);
    for (int i = 0; i < 4; i++) tms(i == 3, v[i]);
    tms(1, 0); tms(0, 0); tms(0, 0);
  endtask
  task dr(input logic [31:0] v, input int n);
    tms(1, 0); tms(0, 0); tms(0, 0);
    for (int i = 0; i < n; i++) tms(i == n - 1, v[i]);
    tms(1, 0); tms(0, 0); tms(0, 0);
  endtask
  task exit_dbg;
    coreDebugExit = 1; wt(1); coreDebugExit = 0; wt(2);
    chk(debug_acknowledge, 0);
  endtask
  task wait_ack;
    repeat (10) if (debug_acknowledge !== 1'b1) wt(1);
  endtask
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  initial begin
    {sys_clk, clkEnable, debug_feature_enable, external_debug_request, data_watchpoint_in, instr_breakpoint_in,
      coreRxFull, coreTxEmpty, coreDataReqEnd, coreFetchEnd, coreExecAdvance, coreExecPassed, coreDebugExit,
      test_clock_qualifier, test_mode_select, test_serial_in, trace_port_enable, coreMultiple, coreDataReq,
      coreWriteNext, coreSeqNext, coreCpFirstMem, corePrevAbort} = '0;
    {external_break_condition, coreWatchHit, coreHsDecode, coreHsExecute, coreDataSize} = '0;
    tap_ident_value = '0;
    reset = 1; debug_reset_n = 1;
    expTr = {`DTP_HS_ABSENT, `DTP_HS_ABSENT, 7'h00};
    r = $urandom(32'h28ad);
    wt(3); reset = 0; wt(6);
    // debug stays disabled here, so random watch and request traffic must not halt
    repeat (80) begin
      chk(trOut, expTr);
      chk({debug_acknowledge, debugHalt, internal_debug_request}, 0);
      r = $urandom;
      {coreHsDecode, coreHsExecute, coreDataSize, coreMultiple, coreDataReq, coreWriteNext, coreSeqNext,
        coreCpFirstMem, corePrevAbort, trace_port_enable, clkEnable, test_clock_qualifier, test_mode_select,
        test_serial_in, data_watchpoint_in, coreDataReqEnd, external_debug_request, external_break_condition} = r[21:0];
      // trace model: one stage late, more and late cancel gated as the rules say
      if (trace_port_enable && clkEnable)
        expTr = {coreHsDecode, coreHsExecute, coreDataSize, coreMultiple & coreDataReq, coreDataReq, coreWriteNext,
          coreSeqNext, coreCpFirstMem & corePrevAbort};
      wt(1);
    end
    {trace_port_enable, data_watchpoint_in, coreDataReqEnd, external_debug_request} = '0;
    {clkEnable, test_clock_qualifier, debug_feature_enable} = 3'h7;
    wt(8);
    repeat (8) begin
      r = $urandom;
      {coreRxFull, coreTxEmpty, coreExecPassed, coreWatchHit} = r[4:0]; wt(1);
      chk({comms_rx_full, comms_tx_empty, instr_executed, watch_match_out}, r[4:0]);
    end
    repeat (5) tms(1, 0);
    tms(0, 0);
    ir(`DTP_IR_SCAN_N); chk({tap_instr_reg_out, tap_state_out}, {`DTP_IR_SCAN_N, `DTP_TS_IDLE});
    dr(`DTP_CHAIN_DCR, 5); chk(selected_chain_id, `DTP_CHAIN_DCR);
    ir(`DTP_IR_INTEST); dr(3'h2, 3);
    external_debug_request = 1;
    repeat (10) if (internal_debug_request !== 1'b1) wt(1);
    chk(internal_debug_request, 1);
    wait_ack(); chk(debug_acknowledge, 1);
    external_debug_request = 0; wt(6); exit_dbg();
    data_watchpoint_in = 1; wt(3); chk(debug_acknowledge, 0);
    coreDataReqEnd = 1; wt(1); {data_watchpoint_in, coreDataReqEnd} = '0;
    wait_ack(); chk({debug_acknowledge, debugHalt}, 2'h3);
    exit_dbg();
    {instr_breakpoint_in, coreFetchEnd} = 2'h3; wt(1); {instr_breakpoint_in, coreFetchEnd} = '0;
    wt(3); chk(debug_acknowledge, 0);
    coreExecAdvance = 1; wt(1); coreExecAdvance = 0;
    wait_ack(); chk(debug_acknowledge, 1);
    exit_dbg();
    tap_ident_value = $urandom;
    ir(`DTP_IR_IDENT); q.delete(); dr(0, 32);
    chk(q.size(), 32);
    for (int i = 0; i < 32; i++) got[i] = (i < q.size()) ? q[i] : 1'bx;
    chk(got, tap_ident_value);
    ir(`DTP_IR_SCAN_N); dr(5'h05, 5); chk(selected_chain_id, 5'h05);
    // other chains go out through the partner: two design stages plus its one flop
    ir(`DTP_IR_INTEST); q.delete(); r = $urandom; dr(r, 16);
    chk(q.size(), 16);
    for (int i = 0; i < 16; i++) got[i] = (i < q.size()) ? q[i] : 1'bx;
    chk(got[15:0], {r[13:0], 2'h0});
    external_debug_request = 1; wait_ack();
    ir(`DTP_IR_BYPASS); chk(tap_instr_reg_out, `DTP_IR_BYPASS);
    debug_reset_n = 0; wt(6);
    chk({debug_acknowledge, internal_debug_request}, 0);
    chk(tap_instr_reg_out, `DTP_IR_IDENT);
    debug_reset_n = 1; wt(10);
    chk(internal_debug_request, 0);
    {data_watchpoint_in, coreDataReqEnd} = 2'h3; wt(1); {data_watchpoint_in, coreDataReqEnd} = '0;
    wait_ack(); chk({debug_acknowledge, debugHalt}, 2'h3);
    debug_feature_enable = 0; wt(10);
    chk({debug_acknowledge, debugHalt, internal_debug_request}, 0);
    {data_watchpoint_in, coreDataReqEnd} = 2'h3; wt(3);
    chk({debug_acknowledge, debugHalt}, 0);
    end_sim();
  end
endmodule // tb_debug_trace_signal_port
bind dtp_debug_trace_port dtp_debug_trace_port_assertions u_chk (.*);
